/* File: hdl/eeprm_fifo.sv */
// Parameterised byte FIFO with synchronous flush
`timescale 1ns/1ps
module eeprm_fifo
  import eeprm_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_n_i,    // Synchronous reset, active low
  eeprm_fifo_if.fifo fif       // Push and pop sides
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  // Extra pointer bit tells full from empty without a counter
  assign empty          = (wr_ptr == rd_ptr);
  assign full           = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign fif.push_ready = ~full & ~fif.flush;
  assign fif.pop_valid  = ~empty & ~fif.flush;
  assign fif.pop_data   = store[rd_ptr[PW-1:0]];
  assign do_push        = fif.push_valid & fif.push_ready;
  assign do_pop         = fif.pop_ready & fif.pop_valid;

  // Storage write
  always_ff @(posedge core_clk_i) begin
    if (do_push) begin
      store[wr_ptr[PW-1:0]] <= fif.push_data;
    end
  end

  // Pointers; flush drops every queued byte
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || fif.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + (PW+1)'(1);
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + (PW+1)'(1);
      end
    end
  end
endmodule

/* File: hdl/eeprm_fifo_if.sv */
// Carrier between the read prefetcher and the byte FIFO
`timescale 1ns/1ps
interface eeprm_fifo_if #(parameter int unsigned WIDTH = 8);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic             flush;
  modport fifo (input push_valid, push_data, pop_ready, flush,
                output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready, flush,
                input push_ready, pop_valid, pop_data);
endinterface

/* File: hdl/eeprm_pkg.sv */
// Constants and types shared by the serial EEPROM read/protect block
package eeprm_pkg;
  // Timebase
  localparam int unsigned CLK_HZ                  = 25_000_000;
  localparam int unsigned RESET_TIMEOUT_PERIOD_MS = 200;
  localparam int unsigned TICK_PERIOD_US          = 1000;
  localparam int unsigned TICK_CYCLES             = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int unsigned TICK_CNT_W              = 15;
  localparam int unsigned MS_CNT_W                = 8;
  localparam logic [MS_CNT_W-1:0] MS_LAST         = MS_CNT_W'(RESET_TIMEOUT_PERIOD_MS - 1);
  // Array and buffer geometry
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned MEM_DEPTH  = 2048;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
  // Slave address byte layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int unsigned DEV_LSB = 4;
  localparam int unsigned HI_LSB  = 1;
  localparam int unsigned RW_BIT  = 0;
  // Bit counter values
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE  = 4'h1;
  localparam logic [3:0] BIT_FULL = 4'h8;
  // Synchroniser idle levels {wp, rst_lo_n, rst_hi, sda, scl}
  localparam logic [4:0] SYNC_RST = 5'h0b;
  // Slave sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_WADR = 7'h04,
    ST_WDAT = 7'h08,
    ST_ACK  = 7'h10,
    ST_RDAT = 7'h20,
    ST_RACK = 7'h40
  } eeprm_state_type;
endpackage

/* File: hdl/eeprm_top.sv */
// Serial EEPROM slave: protected reads, writes and manual reset timing
`timescale 1ns/1ps
// Function
// - Write-protect pin high makes the whole array read-only.
// - Under protection, ack slave and byte address, then nack first data byte.
// - Current-address, random and sequential reads are all supported.
// - Address counter holds last accessed address plus one.
// - Counter rolls from top address 2047 to zero and keeps sending.
// - Current read acks the read address then sends one byte at counter.
// - After repeated start with read selected, ack and send loaded byte.
// - Each master acknowledge requests one further byte.
// - Reads increment all eleven counter bits, not only page bits.
// - A sequential read past the top wraps to zero without stopping.
// - Either reset pin acts as manual reset, sensed by edge only.
// - Rising edge on high reset pin, falling edge on low reset pin.
// - A manual reset edge starts a 200 ms internal count.
// - While counting, drive the complementary reset output active.
// - At expiry release the complementary output, even if input held.
// - Memory access is disabled while either reset pin is active.
// - Input held past the timeout keeps every access unacknowledged.
// - Slave address upper nibble 1010, three high address bits, direction bit.
// - No acknowledge while either reset output is active.
module eeprm_top
  import eeprm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic core_clk_i,    // Core clock, 25 MHz
  input  wire logic rst_n_i,       // Synchronous reset, active low
  input  wire logic scl_i,         // Bus clock pin
  input  wire logic sda_i,         // Bus data pin, input side
  output logic      sda_o,         // Bus data pin, output value
  output logic      sda_oe_n_o,    // Bus data drive enable, low drives
  input  wire logic wp_i,          // Write-protect pin
  input  wire logic rst_hi_i,      // Active-high reset pin, input side
  output logic      rst_hi_o,      // Active-high reset pin, output value
  output logic      rst_hi_oe_n_o, // Active-high reset drive enable, low drives
  input  wire logic rst_lo_n_i,    // Active-low reset pin, input side
  output logic      rst_lo_n_o,    // Active-low reset pin, output value
  output logic      rst_lo_oe_n_o  // Active-low reset drive enable, low drives
);
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES_P - 1);

  logic [4:0]          sy1;
  logic [4:0]          sy2;
  logic [4:0]          sy3;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_cond;
  logic                stop_cond;
  logic                hi_rise;
  logic                lo_fall;
  logic                wp_s;
  logic                mem_block;
  logic                tmr_act;
  logic [TICK_CNT_W-1:0] tick_cnt;
  logic [MS_CNT_W-1:0] ms_cnt;
  logic                tick;
  logic                trig_hi;
  logic                trig_lo;
  eeprm_state_type     st;
  eeprm_state_type     ack_nxt;
  logic [3:0]          bitcnt;
  logic [7:0]          shreg;
  logic [7:0]          txbyte;
  logic [2:0]          hi3;
  logic                more;
  logic [ADDR_W-1:0]   addr_cnt;
  logic [ADDR_W-1:0]   pf_addr;
  logic [DATA_W-1:0]   mem [MEM_DEPTH];
  logic                rx_full;
  logic                load_tx;
  logic                wr_go;
  logic                ld_evt;
  logic                flush_q;

  eeprm_fifo_if #(.WIDTH(DATA_W)) fbus ();

  // Pin synchronisers; only sy2 and later stages feed logic
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sy1 <= SYNC_RST;
      sy2 <= SYNC_RST;
      sy3 <= SYNC_RST;
    end else begin
      sy1 <= {wp_i, rst_lo_n_i, rst_hi_i, sda_i, scl_i};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  // Edge and bus condition detection on synchronised levels
  assign scl_rise   = sy2[0] & ~sy3[0];
  assign scl_fall   = ~sy2[0] & sy3[0];
  assign start_cond = sy2[0] & sy3[0] & ~sy2[1] & sy3[1];
  assign stop_cond  = sy2[0] & sy3[0] & sy2[1] & ~sy3[1];
  assign hi_rise    = sy2[2] & ~sy3[2];
  assign lo_fall    = ~sy2[3] & sy3[3];
  assign wp_s       = sy2[4];

  // Only the active edge starts a timeout; a held level does nothing more
  assign trig_hi = hi_rise & ~tmr_act;
  assign trig_lo = lo_fall & ~tmr_act;
  assign tick    = tmr_act && (tick_cnt == TICK_LAST);

  // Pin levels include our own drive, so the timeout also blocks access
  assign mem_block = sy2[2] | ~sy2[3] | tmr_act;

  // Millisecond divider and timeout counter
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tick_cnt <= '0;
      ms_cnt   <= '0;
      tmr_act  <= 1'b0;
    end else if (trig_hi || trig_lo) begin
      tick_cnt <= '0;
      ms_cnt   <= '0;
      tmr_act  <= 1'b1;
    end else if (tmr_act) begin
      tick_cnt <= tick ? '0 : tick_cnt + TICK_CNT_W'(1);
      if (tick) begin
        ms_cnt <= ms_cnt + MS_CNT_W'(1);
        if (ms_cnt == MS_LAST) begin
          tmr_act <= 1'b0;
        end
      end
    end
  end

  // Complementary reset drive: the opposite pin of the one that fired
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rst_hi_oe_n_o <= 1'b1;
      rst_lo_oe_n_o <= 1'b1;
    end else if (trig_hi) begin
      rst_lo_oe_n_o <= 1'b0;
    end else if (trig_lo) begin
      rst_hi_oe_n_o <= 1'b0;
    end else if (tick && ms_cnt == MS_LAST) begin
      rst_hi_oe_n_o <= 1'b1;
      rst_lo_oe_n_o <= 1'b1;
    end
  end

  // Open-drain style pins: only the enables move
  assign sda_o      = 1'b0;
  assign rst_hi_o   = 1'b1;
  assign rst_lo_n_o = 1'b0;

  // Byte-level decisions taken on the falling bus clock edge
  assign rx_full = scl_fall && (bitcnt == BIT_FULL);
  assign load_tx = scl_fall && ((st == ST_ACK && ack_nxt == ST_RDAT) ||
                                (st == ST_RACK && more));
  assign wr_go   = rx_full && st == ST_WDAT && !wp_s && !mem_block;

  // Slave sequencer
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st         <= ST_IDLE;
      ack_nxt    <= ST_IDLE;
      bitcnt     <= BIT_ZERO;
      shreg      <= '0;
      txbyte     <= '0;
      hi3        <= '0;
      more       <= 1'b0;
      sda_oe_n_o <= 1'b1;
      addr_cnt   <= ADDR_RST;
      ld_evt     <= 1'b0;
    end else begin
      ld_evt <= 1'b0;
      if (start_cond) begin
        st         <= ST_ADDR;
        bitcnt     <= BIT_ZERO;
        sda_oe_n_o <= 1'b1;
      end else if (stop_cond || (mem_block && st != ST_IDLE)) begin
        st         <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else if (scl_rise) begin
        if (st == ST_ADDR || st == ST_WADR || st == ST_WDAT) begin
          shreg  <= {shreg[6:0], sy2[1]};
          bitcnt <= bitcnt + BIT_ONE;
        end
        if (st == ST_RACK) begin
          more <= ~sy2[1];
        end
      end else if (scl_fall) begin
        case (st)
          ST_ADDR: begin
            if (rx_full) begin
              bitcnt <= BIT_ZERO;
              if (shreg[7:DEV_LSB] == DEV_TYPE) begin
                st         <= ST_ACK;
                sda_oe_n_o <= 1'b0;
                hi3        <= shreg[DEV_LSB-1:HI_LSB];
                ack_nxt    <= shreg[RW_BIT] ? ST_RDAT : ST_WADR;
              end else begin
                st <= ST_IDLE;
              end
            end
          end
          ST_WADR: begin
            if (rx_full) begin
              addr_cnt   <= {hi3, shreg};
              ld_evt     <= 1'b1;
              bitcnt     <= BIT_ZERO;
              st         <= ST_ACK;
              sda_oe_n_o <= 1'b0;
              ack_nxt    <= ST_WDAT;
            end
          end
          ST_WDAT: begin
            if (rx_full) begin
              bitcnt <= BIT_ZERO;
              if (wp_s) begin
                st <= ST_IDLE;
              end else begin
                addr_cnt   <= addr_cnt + ADDR_ONE;
                ld_evt     <= 1'b1;
                st         <= ST_ACK;
                sda_oe_n_o <= 1'b0;
                ack_nxt    <= ST_WDAT;
              end
            end
          end
          ST_ACK: begin
            if (ack_nxt == ST_RDAT) begin
              // First bit goes out as the acknowledge clock ends
              txbyte     <= {fbus.pop_data[6:0], 1'b0};
              sda_oe_n_o <= fbus.pop_data[7];
              addr_cnt   <= addr_cnt + ADDR_ONE;
              bitcnt     <= BIT_ONE;
              st         <= ST_RDAT;
            end else begin
              sda_oe_n_o <= 1'b1;
              bitcnt     <= BIT_ZERO;
              st         <= ack_nxt;
            end
          end
          ST_RDAT: begin
            if (bitcnt == BIT_FULL) begin
              sda_oe_n_o <= 1'b1;
              st         <= ST_RACK;
            end else begin
              sda_oe_n_o <= txbyte[7];
              txbyte     <= {txbyte[6:0], 1'b0};
              bitcnt     <= bitcnt + BIT_ONE;
            end
          end
          ST_RACK: begin
            if (more) begin
              txbyte     <= {fbus.pop_data[6:0], 1'b0};
              sda_oe_n_o <= fbus.pop_data[7];
              addr_cnt   <= addr_cnt + ADDR_ONE;
              bitcnt     <= BIT_ONE;
              st         <= ST_RDAT;
            end else begin
              st <= ST_IDLE;
            end
          end
          default: begin
            st <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Array write; the protect pin gates the strobe itself
  always_ff @(posedge core_clk_i) begin
    if (wr_go) begin
      mem[addr_cnt] <= shreg;
    end
  end

  // Prefetch restarts at the counter whenever idle or after any reload
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flush_q <= 1'b1;
      pf_addr <= ADDR_RST;
    end else begin
      flush_q <= (st == ST_IDLE) | ld_evt;
      if (flush_q) begin
        pf_addr <= addr_cnt;
      end else if (fbus.push_valid && fbus.push_ready) begin
        pf_addr <= pf_addr + ADDR_ONE;
      end
    end
  end

  // Buffer hookup; a full buffer stalls the prefetcher
  assign fbus.push_valid = ~flush_q;
  assign fbus.push_data  = mem[pf_addr];
  assign fbus.pop_ready  = load_tx;
  assign fbus.flush      = flush_q;

  eeprm_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i   (rst_n_i),
    .fif       (fbus.fifo)
  );

  // Checks on the sequencer and reset timer
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_addr_byte_ok;
    st == ST_ADDR && rx_full && shreg[7:DEV_LSB] == DEV_TYPE && !mem_block;
  endsequence
  sequence s_ack_driven;
    st == ST_ACK && !sda_oe_n_o;
  endsequence

  // Looks at the stored byte itself, so a broken write gate is caught too
  AST_WP_NO_PROGRAM: assert property (st == ST_WDAT && rx_full && wp_s
    |=> mem[$past(addr_cnt)] == $past(mem[addr_cnt]))
    else $error("array written while protected");
  AST_WP_NACK: assert property (st == ST_WDAT && rx_full && wp_s && !mem_block
    |=> st == ST_IDLE && sda_oe_n_o)
    else $error("protected data byte was acknowledged");
  AST_ADDR_ACK: assert property (s_addr_byte_ok |=> s_ack_driven)
    else $error("matching slave address not acknowledged");
  AST_READ_START: assert property (st == ST_ACK && ack_nxt == ST_RDAT && scl_fall
    && !mem_block
    |=> st == ST_RDAT && bitcnt == BIT_ONE && addr_cnt == $past(addr_cnt) + ADDR_ONE)
    else $error("read byte did not start after acknowledge");
  AST_CNT_WRAP: assert property (load_tx && !mem_block && addr_cnt == ~ADDR_RST
    |=> addr_cnt == ADDR_RST)
    else $error("counter did not wrap to zero");
  AST_RELEASE: assert property (st == ST_RDAT && scl_fall && bitcnt == BIT_FULL
    && !mem_block |=> st == ST_RACK && sda_oe_n_o)
    else $error("data line held for master acknowledge");
  AST_MORE: assert property (st == ST_RACK && scl_fall && more && !mem_block
    |=> st == ST_RDAT)
    else $error("acknowledged read did not continue");
  AST_NACK_IDLE: assert property (st == ST_RACK && scl_fall && !more && !start_cond
    && !stop_cond && !mem_block |=> st == ST_IDLE ##1 flush_q)
    else $error("read not ended on missing acknowledge");
  AST_BLOCK: assert property (mem_block && !start_cond |=> st == ST_IDLE || st == ST_ADDR)
    else $error("access active during reset");
  AST_TRIG: assert property (trig_hi |=> (tmr_act && !rst_lo_oe_n_o) [*3])
    else $error("manual reset did not drive complementary output");
  AST_EXPIRE: assert property (tick && ms_cnt == MS_LAST
    |=> !tmr_act && rst_lo_oe_n_o && rst_hi_oe_n_o)
    else $error("reset output not released at timeout");
  AST_EDGE_ONLY: assert property (!tmr_act && !hi_rise && !lo_fall |=> !tmr_act)
    else $error("timeout started without an edge");
endmodule

/* File: sim/eeprm_i2c_master.sv */
// Two-wire bus master model that paces the bus clock from the core clock
`timescale 1ns/1ps
module eeprm_i2c_master (
  input  wire logic core_clk_i, // Core clock used for pacing
  input  wire logic sda_i,      // Resolved data wire
  output logic      scl_o,      // Bus clock, stands high outside frames
  output logic      sda_low_o   // High pulls the data wire low
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // Low phase 5 clocks, high 3: data moves one clock after the fall, before the device lets go of its ack
  task automatic clk_bit(input logic drv_low, output logic seen);
    wait_clk(1);
    sda_low_o = drv_low;
    wait_clk(4);
    scl_o = 1'b1;
    wait_clk(2);
    seen = sda_i;
    wait_clk(1);
    scl_o = 1'b0;
  endtask

  // Start from idle or a repeated start from mid-frame
  task automatic start();
    if (scl_o === 1'b0) begin
      wait_clk(1);
      sda_low_o = 1'b0;
      wait_clk(4);
      scl_o = 1'b1;
      wait_clk(2);
    end
    sda_low_o = 1'b1;
    wait_clk(3);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    wait_clk(1);
    sda_low_o = 1'b1;
    wait_clk(4);
    scl_o = 1'b1;
    wait_clk(2);
    sda_low_o = 1'b0;
    wait_clk(4);
  endtask

  // Eight bits MSB first, then the ninth clock with the wire released
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], d);
    end
    clk_bit(1'b0, d);
    ack = ~d;
  endtask

  // Master ack asks for one more byte; no ack ends the read
  task automatic read_byte(input logic mack, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, d[i]);
    end
    clk_bit(mack, x);
  endtask
endmodule

/* File: sim/eeprm_top_test.sv */
// Self-checking bench for the protected serial EEPROM slave
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module eeprm_top_test;
  import eeprm_pkg::*;
  localparam int unsigned TICKS = 10;
  localparam int unsigned TOUT  = 200 * TICKS;
  localparam int unsigned LIMIT = 40000;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wp = 1'b0;
  logic       rst_hi_drv = 1'b0;
  logic       rst_lo_drv_n = 1'b1;
  logic       scl, sda_low, sda_o, sda_oe_n, rst_hi_o, rst_hi_oe_n, rst_lo_n_o, rst_lo_oe_n;
  wire        sda, rst_hi_w, rst_lo_w;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  logic       ack;
  logic [7:0] d;

  // Wired levels: pull-up on data, each party only pulls its own way
  assign sda      = ~sda_low & (sda_oe_n | sda_o);
  assign rst_hi_w = rst_hi_drv | (~rst_hi_oe_n & rst_hi_o);
  assign rst_lo_w = rst_lo_drv_n & (rst_lo_oe_n | rst_lo_n_o);

  always #20 clk = ~clk;

  eeprm_top #(.TICK_CYCLES_P(TICKS)) u_eeprm_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .wp_i(wp), .rst_hi_i(rst_hi_w), .rst_hi_o(rst_hi_o),
    .rst_hi_oe_n_o(rst_hi_oe_n), .rst_lo_n_i(rst_lo_w), .rst_lo_n_o(rst_lo_n_o),
    .rst_lo_oe_n_o(rst_lo_oe_n));

  eeprm_i2c_master u_eeprm_i2c_master (
    .core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  function automatic logic [7:0] pat(input int i);
    return 8'h3c + 8'(i) * 8'h11;
  endfunction

  // Dummy write: slave byte with write selected, then low address byte
  task automatic addr_write(input logic [10:0] a);
    u_eeprm_i2c_master.start();
    u_eeprm_i2c_master.write_byte({4'ha, a[10:8], 1'b0}, ack);
    `CHK(ack, 1'b1)
    u_eeprm_i2c_master.write_byte(a[7:0], ack);
    `CHK(ack, 1'b1)
  endtask

  // Random read of n bytes from a, each compared with the pattern from index k
  task automatic rd_seq(input logic [10:0] a, input int n, input int k);
    addr_write(a);
    u_eeprm_i2c_master.start();
    u_eeprm_i2c_master.write_byte({4'ha, a[10:8], 1'b1}, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      u_eeprm_i2c_master.read_byte(i < n - 1, d);
      `CHK(d, pat(k + i))
    end
    u_eeprm_i2c_master.stop();
  endtask

  // Slave byte on its own, acknowledge compared with exp
  task automatic probe(input logic [7:0] sb, input logic exp);
    u_eeprm_i2c_master.start();
    u_eeprm_i2c_master.write_byte(sb, ack);
    `CHK(ack, exp)
    u_eeprm_i2c_master.stop();
  endtask

  task automatic count_low(input bit hi_side, output int n);
    int w;
    w = 0;
    n = 0;
    while ((hi_side ? rst_hi_oe_n : rst_lo_oe_n) !== 1'b0 && w < 20) begin
      w++;
      @(negedge clk);
    end
    while ((hi_side ? rst_hi_oe_n : rst_lo_oe_n) === 1'b0 && n < TOUT + 50) begin
      n++;
      @(negedge clk);
    end
  endtask

  // Eleven bytes across the top of the array; the last lands at 0x005
  task automatic t_write_wrap();
    addr_write(11'h7fb);
    for (int i = 0; i < 11; i++) begin
      u_eeprm_i2c_master.write_byte(pat(i), ack);
      `CHK(ack, 1'b1)
    end
    u_eeprm_i2c_master.stop();
    $display("test write_wrap done");
  endtask

  // Ten bytes past the wrap, more than the prefetch buffer holds
  task automatic t_seq_read();
    rd_seq(11'h7fb, 10, 0);
    $display("test seq_read done");
  endtask

  // Counter kept after the nack: the next current read is address 0x005
  task automatic t_current_read();
    u_eeprm_i2c_master.start();
    u_eeprm_i2c_master.write_byte(8'ha1, ack);
    `CHK(ack, 1'b1)
    u_eeprm_i2c_master.read_byte(1'b0, d);
    `CHK(d, pat(10))
    u_eeprm_i2c_master.stop();
    $display("test current_read done");
  endtask

  task automatic t_protect();
    wp = 1'b1;
    addr_write(11'h7fb);
    u_eeprm_i2c_master.write_byte(8'h00, ack);
    `CHK(ack, 1'b0)
    u_eeprm_i2c_master.stop();
    wp = 1'b0;
    rd_seq(11'h7fb, 1, 0);
    probe(8'h93, 1'b0);
    $display("test protect done");
  endtask

  // Short pulse on the high pin; access tried while the low pin is driven
  task automatic t_reset_hi();
    int n;
    rst_hi_drv = 1'b1;
    repeat (2) @(negedge clk);
    rst_hi_drv = 1'b0;
    fork
      count_low(1'b0, n);
      begin
        repeat (30) @(negedge clk);
        `CHK(rst_lo_w, 1'b0)
        probe(8'ha1, 1'b0);
      end
    join
    `CHK(n, TOUT)
    `CHK(rst_hi_oe_n, 1'b1)
    // Released pin level needs a few clocks through the synchroniser
    repeat (4) @(negedge clk);
    rd_seq(11'h000, 1, 5);
    $display("test reset_hi done");
  endtask

  // Low pin held past the timeout: output released, access still refused
  task automatic t_reset_lo_held();
    int n;
    rst_lo_drv_n = 1'b0;
    count_low(1'b1, n);
    `CHK(n, TOUT)
    probe(8'ha1, 1'b0);
    rst_lo_drv_n = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(rst_hi_oe_n, 1'b1)
    probe(8'ha0, 1'b1);
    $display("test reset_lo_held done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_write_wrap();
    t_seq_read();
    t_current_read();
    t_protect();
    t_reset_hi();
    t_reset_lo_held();
    tally_and_finish();
  end
endmodule
